// ==== include/pio_consts.vh ====
// constants for the port latch and mode block
`ifndef PIO_CONSTS_VH
`define PIO_CONSTS_VH

// register offsets
`define PIO_ADDR_PORT0_LATCH 8'h80
`define PIO_ADDR_PORT1_LATCH 8'h90
`define PIO_ADDR_PORT2_LATCH 8'hA0
`define PIO_ADDR_PORT3_LATCH 8'hB0
`define PIO_ADDR_PORT0_DRIVE 8'hA4
`define PIO_ADDR_PORT1_DRIVE 8'hA5
`define PIO_ADDR_PORT2_DRIVE 8'hA6
`define PIO_ADDR_PORT3_DRIVE 8'hA7
`define PIO_ADDR_PORT0_ANALOG 8'hF1
`define PIO_ADDR_PORT1_ANALOG 8'hF2
`define PIO_ADDR_PORT2_ANALOG 8'hF3
`define PIO_ADDR_PORT3_ANALOG 8'hF4
`define PIO_ADDR_XBAR_CTRL 8'hE2

// field positions
`define PIO_XBAR_EN_BIT 6
`define PIO_P3_USED_MASK 8'h01

// reset values
`define PIO_RST_LATCH 8'hFF
`define PIO_RST_DRIVE 8'h00
`define PIO_RST_ANALOG 8'hFF
`define PIO_RST_P3_ANALOG 8'h01
`define PIO_RST_XBAR 8'h00

`endif

// ==== rtl/pio_pin_sync.v ====
// two-flop synchroniser for the 25 pin input levels
`timescale 1ns/10ps
`default_nettype none

module pio_pin_sync
(
  // clock and reset
  input wire MCLK,
  input wire RST,
  // raw and synchronised pin levels
  input wire [24:0] pin_raw,
  output reg [24:0] pin_sync
);

  reg [24:0] stage1;

  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      stage1 <= 25'h1FFFFFF;
      pin_sync <= 25'h1FFFFFF;
    end
    else
    begin
      stage1 <= pin_raw;
      pin_sync <= stage1;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/pio_port_io.v ====
// port data latches, drive and analog mode registers, pin drivers
`include "pio_consts.vh"
`timescale 1ns/10ps
`default_nettype none

// Contract
// - latch drives pins 19:0 only when crossbar enabled; upper port 2 and port 3 pins regardless
// - open-drain pin floats when latch is one
// - analog pins read as zero
// - digital pins read live synchronised pin level
// - all four port latches reset high
// - drive bit picks push-pull, ignored if analog
// - SMBus pins always open-drain
// - analog select zero disables pull-up, driver, receiver
// - upper port 2 pins ignore crossbar enable
// - crossbar off keeps routed pins undriven
module pio_port_io
(
  // clock and reset
  input wire MCLK,
  input wire RST,
  // register port
  input wire [7:0] SFR_ADDR,
  input wire SFR_WR,
  input wire SFR_RD,
  input wire [7:0] SFR_WDATA,
  output reg [7:0] SFR_RDATA,
  // smbus placement, one bit per pin of ports 0 to 2
  input wire [23:0] SMB_PIN,
  // pins: ports 0..2 in bits 23:0, port 3 bit 0 in bit 24
  input wire [24:0] PIN_IN,
  output reg [24:0] PIN_OUT,
  output reg [24:0] PIN_OE,
  output reg [24:0] PIN_PULLUP,
  output reg [24:0] PIN_RX_EN
);

  // ===========================================================
  // register storage
  reg [7:0] port0_data_latch;
  reg [7:0] port1_data_latch;
  reg [7:0] port2_data_latch;
  reg [7:0] port3_data_latch;
  reg [7:0] port0_output_drive_mode;
  reg [7:0] port1_output_drive_mode;
  reg [7:0] port2_output_drive_mode;
  reg [7:0] port3_output_drive_mode;
  reg [7:0] port0_analog_select;
  reg [7:0] port1_analog_select;
  reg [7:0] port2_analog_select;
  reg [7:0] port3_analog_select;
  reg [7:0] xbar_ctrl;
  reg [23:0] smb_s1;
  reg [23:0] smb_sync;
  wire [24:0] pin_sync;
  wire crossbar_enable;

  assign crossbar_enable = xbar_ctrl[`PIO_XBAR_EN_BIT];

  pio_pin_sync u_sync
  (
    .MCLK(MCLK),
    .RST(RST),
    .pin_raw(PIN_IN),
    .pin_sync(pin_sync)
  );

  // read value of one port: analog bits zero, digital bits live
  function [7:0] port_read;
    input [7:0] analog_sel;
    input [7:0] level;
    begin
      port_read = analog_sel & level;
    end
  endfunction

  // address match for one register
  function addr_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // ===========================================================
  // write strobes, one per register
  // unmapped addresses raise no strobe, so such writes are dropped
  wire wr_port0_latch;
  wire wr_port1_latch;
  wire wr_port2_latch;
  wire wr_port3_latch;
  wire wr_port0_drive;
  wire wr_port1_drive;
  wire wr_port2_drive;
  wire wr_port3_drive;
  wire wr_port0_analog;
  wire wr_port1_analog;
  wire wr_port2_analog;
  wire wr_port3_analog;
  wire wr_xbar;

  assign wr_port0_latch = SFR_WR & addr_hit(SFR_ADDR, `PIO_ADDR_PORT0_LATCH);
  assign wr_port1_latch = SFR_WR & addr_hit(SFR_ADDR, `PIO_ADDR_PORT1_LATCH);
  assign wr_port2_latch = SFR_WR & addr_hit(SFR_ADDR, `PIO_ADDR_PORT2_LATCH);
  assign wr_port3_latch = SFR_WR & addr_hit(SFR_ADDR, `PIO_ADDR_PORT3_LATCH);
  assign wr_port0_drive = SFR_WR & addr_hit(SFR_ADDR, `PIO_ADDR_PORT0_DRIVE);
  assign wr_port1_drive = SFR_WR & addr_hit(SFR_ADDR, `PIO_ADDR_PORT1_DRIVE);
  assign wr_port2_drive = SFR_WR & addr_hit(SFR_ADDR, `PIO_ADDR_PORT2_DRIVE);
  assign wr_port3_drive = SFR_WR & addr_hit(SFR_ADDR, `PIO_ADDR_PORT3_DRIVE);
  assign wr_port0_analog = SFR_WR & addr_hit(SFR_ADDR, `PIO_ADDR_PORT0_ANALOG);
  assign wr_port1_analog = SFR_WR & addr_hit(SFR_ADDR, `PIO_ADDR_PORT1_ANALOG);
  assign wr_port2_analog = SFR_WR & addr_hit(SFR_ADDR, `PIO_ADDR_PORT2_ANALOG);
  assign wr_port3_analog = SFR_WR & addr_hit(SFR_ADDR, `PIO_ADDR_PORT3_ANALOG);
  assign wr_xbar = SFR_WR & addr_hit(SFR_ADDR, `PIO_ADDR_XBAR_CTRL);

  // port data latches
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      port0_data_latch <= `PIO_RST_LATCH;
      port1_data_latch <= `PIO_RST_LATCH;
      port2_data_latch <= `PIO_RST_LATCH;
      port3_data_latch <= `PIO_RST_LATCH;
    end
    else
    begin
      if (wr_port0_latch)
        port0_data_latch <= SFR_WDATA;
      if (wr_port1_latch)
        port1_data_latch <= SFR_WDATA;
      if (wr_port2_latch)
        port2_data_latch <= SFR_WDATA;
      if (wr_port3_latch)
        port3_data_latch <= SFR_WDATA;
    end
  end

  // output drive mode; port 3 keeps bit zero only
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      port0_output_drive_mode <= `PIO_RST_DRIVE;
      port1_output_drive_mode <= `PIO_RST_DRIVE;
      port2_output_drive_mode <= `PIO_RST_DRIVE;
      port3_output_drive_mode <= `PIO_RST_DRIVE;
    end
    else
    begin
      if (wr_port0_drive)
        port0_output_drive_mode <= SFR_WDATA;
      if (wr_port1_drive)
        port1_output_drive_mode <= SFR_WDATA;
      if (wr_port2_drive)
        port2_output_drive_mode <= SFR_WDATA;
      if (wr_port3_drive)
        port3_output_drive_mode <= SFR_WDATA & `PIO_P3_USED_MASK;
    end
  end

  // analog select; port 3 keeps bit zero only
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      port0_analog_select <= `PIO_RST_ANALOG;
      port1_analog_select <= `PIO_RST_ANALOG;
      port2_analog_select <= `PIO_RST_ANALOG;
      port3_analog_select <= `PIO_RST_P3_ANALOG;
    end
    else
    begin
      if (wr_port0_analog)
        port0_analog_select <= SFR_WDATA;
      if (wr_port1_analog)
        port1_analog_select <= SFR_WDATA;
      if (wr_port2_analog)
        port2_analog_select <= SFR_WDATA;
      if (wr_port3_analog)
        port3_analog_select <= SFR_WDATA & `PIO_P3_USED_MASK;
    end
  end

  // crossbar control, bits other than the enable are plain storage
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
      xbar_ctrl <= `PIO_RST_XBAR;
    else if (wr_xbar)
      xbar_ctrl <= SFR_WDATA;
  end

  // smbus placement comes from peripheral logic; synchronise as a level
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      smb_s1 <= 24'h000000;
      smb_sync <= 24'h000000;
    end
    else
    begin
      smb_s1 <= SMB_PIN;
      smb_sync <= smb_s1;
    end
  end

  // ===========================================================
  // pin drive decision
  reg [24:0] all_latch;
  reg [24:0] all_drive;
  reg [24:0] all_analog;
  reg [24:0] gpio_free;
  reg [24:0] open_drain;
  reg [24:0] next_out;
  reg [24:0] next_oe;
  reg [24:0] next_pullup;
  reg [24:0] next_rx;

  always @*
  begin
    all_latch = {port3_data_latch[0], port2_data_latch, port1_data_latch,
      port0_data_latch};
    all_drive = {port3_output_drive_mode[0], port2_output_drive_mode,
      port1_output_drive_mode, port0_output_drive_mode};
    all_analog = {port3_analog_select[0], port2_analog_select,
      port1_analog_select, port0_analog_select};
    // upper port 2 and port 3 pins are always plain gpio
    gpio_free = {1'b1, 4'hF, 20'h00000};
    // open-drain when drive bit low, or smbus on pin
    open_drain = ~all_drive | {1'b0, smb_sync};
    // enable driver only with crossbar on (or free pin) and digital pin
    next_oe = all_analog & (gpio_free | {25{crossbar_enable}}) &
      (~all_latch | ~open_drain);
    next_out = all_latch & next_oe;
    // weak pull-up on digital open-drain pins whose latch is high
    next_pullup = all_analog & open_drain & all_latch;
    next_rx = all_analog;
  end

  // ===========================================================
  // read data selection, zero when no read
  reg [7:0] next_rdata;

  // data registers return pin levels; latch readback is not offered
  always @*
  begin
    next_rdata = 8'h00;
    if (SFR_RD)
    begin
      case (SFR_ADDR)
        `PIO_ADDR_PORT0_LATCH: next_rdata = port_read(port0_analog_select, pin_sync[7:0]);
        `PIO_ADDR_PORT1_LATCH: next_rdata = port_read(port1_analog_select, pin_sync[15:8]);
        `PIO_ADDR_PORT2_LATCH: next_rdata = port_read(port2_analog_select, pin_sync[23:16]);
        `PIO_ADDR_PORT3_LATCH: next_rdata = port_read(port3_analog_select,
          {7'h00, pin_sync[24]});
        `PIO_ADDR_PORT0_DRIVE: next_rdata = port0_output_drive_mode;
        `PIO_ADDR_PORT1_DRIVE: next_rdata = port1_output_drive_mode;
        `PIO_ADDR_PORT2_DRIVE: next_rdata = port2_output_drive_mode;
        `PIO_ADDR_PORT3_DRIVE: next_rdata = port3_output_drive_mode;
        `PIO_ADDR_PORT0_ANALOG: next_rdata = port0_analog_select;
        `PIO_ADDR_PORT1_ANALOG: next_rdata = port1_analog_select;
        `PIO_ADDR_PORT2_ANALOG: next_rdata = port2_analog_select;
        `PIO_ADDR_PORT3_ANALOG: next_rdata = port3_analog_select;
        `PIO_ADDR_XBAR_CTRL: next_rdata = xbar_ctrl;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // ===========================================================
  // registered pin controls
  // pins change one cycle after the write edge, never mid-cycle
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      PIN_OUT <= 25'h0000000;
      PIN_OE <= 25'h0000000;
      PIN_PULLUP <= 25'h0000000;
      PIN_RX_EN <= 25'h0000000;
    end
    else
    begin
      PIN_OUT <= next_out;
      PIN_OE <= next_oe;
      PIN_PULLUP <= next_pullup;
      PIN_RX_EN <= next_rx;
    end
  end

  // registered read data, stands for one cycle
  always @(posedge MCLK or posedge RST)
  begin
    if (RST)
      SFR_RDATA <= 8'h00;
    else
      SFR_RDATA <= next_rdata;
  end

endmodule

`default_nettype wire

// ==== verification/pio_board.sv ====
// board-side pin model resolving each pin level
`timescale 1ns/10ps
`default_nettype none
module pio_board
(
  // clock and device side
  input wire logic mclk,
  input wire logic [24:0] pin_out,
  input wire logic [24:0] pin_oe,
  input wire logic [24:0] pin_pullup,
  // board drivers and resolved level
  input wire logic [24:0] ext_en,
  input wire logic [24:0] ext_val,
  output wire logic [24:0] pin_in
);
  // ======
  // resolve
  logic flip = 1'b0;
  // floating pins wander every cycle
  always @(posedge mclk)
    flip <= ~flip;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
    | (~pin_oe & ~ext_en & (pin_pullup | {25{flip}}));
endmodule
`default_nettype wire

// ==== verification/pio_port_io_asserts.sv ====
// assertions on the port latch and mode block
`timescale 1ns/10ps
`default_nettype none
module pio_port_io_chk
(
  // clock and register port
  input wire logic MCLK,
  input wire logic RST,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  input wire logic SFR_WR,
  input wire logic [7:0] SFR_RDATA,
  // pins
  input wire logic [23:0] SMB_PIN,
  input wire logic [24:0] PIN_IN,
  input wire logic [24:0] PIN_OUT,
  input wire logic [24:0] PIN_OE,
  input wire logic [24:0] PIN_PULLUP,
  input wire logic [24:0] PIN_RX_EN
);
  // ======
  // checks
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence xbar_off; SFR_WR && SFR_ADDR == 8'hE2 && !SFR_WDATA[6]; endsequence
  sequence rd_port0; SFR_RD && SFR_ADDR == 8'h80; endsequence
  sequence rd_port3; SFR_RD && (SFR_ADDR == 8'hA7 || SFR_ADDR == 8'hF4); endsequence
  a_xbar_gates: assert property (xbar_off |-> ##2 PIN_OE[19:0] == 20'h0)
    else $error("gated pin driven");
  a_od_floats: assert property ((PIN_OE & PIN_PULLUP) == 25'h0)
    else $error("pull-up on driven pin");
  a_out_needs_oe: assert property ((PIN_OUT & ~PIN_OE) == 25'h0)
    else $error("high without enable");
  a_analog_off: assert property ((~PIN_RX_EN & (PIN_OE | PIN_PULLUP)) == 25'h0)
    else $error("analog pin active");
  a_smb_od: assert property ($stable(SMB_PIN)[*4] |-> (PIN_OUT[23:0] & SMB_PIN) == 24'h0)
    else $error("smbus pin pushed");
  a_rd_analog: assert property (rd_port0 |=> (SFR_RDATA & ~PIN_RX_EN[7:0]) == 8'h0)
    else $error("analog bit read");
  a_rd_level: assert property ($stable(PIN_IN[7:0])[*4] ##0 rd_port0 ##0 PIN_RX_EN[7:0] == 8'hFF
    |=> SFR_RDATA == $past(PIN_IN[7:0])) else $error("pin level not read");
  a_p3_bits: assert property (rd_port3 |=> SFR_RDATA[7:1] == 7'h0)
    else $error("port3 upper bits set");
endmodule
bind pio_port_io pio_port_io_chk u_chk (.MCLK(MCLK), .RST(RST), .SFR_ADDR(SFR_ADDR),
  .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .SFR_RDATA(SFR_RDATA),
  .SMB_PIN(SMB_PIN), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
  .PIN_PULLUP(PIN_PULLUP), .PIN_RX_EN(PIN_RX_EN));
`default_nettype wire

// ==== verification/tb_pio_port_io.sv ====
// self-checking bench for the port latch and mode block
`timescale 1ns/10ps
`default_nettype none
module tb_pio_port_io;
  // ======
  // bench
  logic mclk = 0, rst = 1, wr = 0, rd = 0;
  logic [7:0] addr = 0, wdata = 0, rdata, l, m, a, v;
  logic [23:0] smb = 0;
  logic [24:0] pin, pout, poe, ppu, prx, ext_en = 0, ext_val = 0;
  int miscompares = 0, n_checks = 0;
  always #25 mclk = ~mclk;
  pio_port_io uut (.MCLK(mclk), .RST(rst), .SFR_ADDR(addr), .SFR_WR(wr), .SFR_RD(rd),
    .SFR_WDATA(wdata), .SFR_RDATA(rdata), .SMB_PIN(smb), .PIN_IN(pin), .PIN_OUT(pout),
    .PIN_OE(poe), .PIN_PULLUP(ppu), .PIN_RX_EN(prx));
  pio_board brd (.mclk(mclk), .pin_out(pout), .pin_oe(poe), .pin_pullup(ppu),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin));
  function automatic logic [7:0] oe1(input logic [7:0] l, m, s, a);
    return a & ((m & ~s) | ~l);
  endfunction
  function automatic logic [7:0] pu1(input logic [7:0] l, m, s, a);
    return a & (~m | s) & l;
  endfunction
  task chk(input string n, input logic [24:0] e, input logic [24:0] g);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task wr_reg(input logic [7:0] ad, input logic [7:0] d);
    @(posedge mclk);
    wr <= 1;
    addr <= ad;
    wdata <= d;
    @(posedge mclk);
    wr <= 0;
  endtask
  task rchk(input string n, input logic [7:0] ad, input logic [7:0] e);
    @(posedge mclk);
    rd <= 1;
    addr <= ad;
    @(posedge mclk);
    rd <= 0;
    #1 chk(n, 25'(e), 25'(rdata));
  endtask
  task settle;
    repeat (4) @(posedge mclk);
    #1;
  endtask
  task tally_and_finish;
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (3000) @(posedge mclk);
    miscompares++;
    tally_and_finish;
  end
  initial
  begin
    void'($urandom(61));
    repeat (16) @(posedge mclk);
    rst <= 0;
    rchk("p1_drive", 8'hA5, 8'h00);
    rchk("p3_drive", 8'hA7, 8'h00);
    rchk("port2_analog", 8'hF3, 8'hFF);
    rchk("p3_analog", 8'hF4, 8'h01);
    rchk("unmapped", 8'h00, 8'h00);
    wr_reg(8'hE2, 8'h00);
    wr_reg(8'hA6, 8'hFF);
    wr_reg(8'hA0, 8'h5A);
    settle;
    chk("port2_oe", 25'h0F00000, poe);
    chk("port2_out", 25'h0500000, pout);
    wr_reg(8'hE2, 8'h40);
    wr_reg(8'hA4, 8'hFF);
    settle;
    chk("port0_out", 25'h05A00FF, pout);
    for (int i = 0; i < 12; i++)
    begin
      @(posedge mclk);
      smb[15:8] <= 8'($urandom);
      l = 8'($urandom);
      m = 8'($urandom);
      a = i == 0 ? 8'hFF : 8'($urandom);
      wr_reg(8'h90, l);
      wr_reg(8'hA5, m);
      wr_reg(8'hF2, a);
      settle;
      chk("p1_oe", 25'(oe1(l, m, smb[15:8], a)), 25'(poe[15:8]));
      chk("p1_out", 25'(l & oe1(l, m, smb[15:8], a)), 25'(pout[15:8]));
      chk("p1_rx", 25'(a), 25'(prx[15:8]));
      chk("p1_pull", 25'(pu1(l, m, smb[15:8], a)), 25'(ppu[15:8]));
    end
    wr_reg(8'hA4, 8'h00);
    for (int i = 0; i < 12; i++)
    begin
      @(posedge mclk);
      ext_en <= 25'hFF;
      v = 8'($urandom);
      ext_val <= 25'(v);
      a = i == 0 ? 8'hFF : 8'($urandom);
      wr_reg(8'hF1, a);
      settle;
      rchk("port0_read", 8'h80, a & v);
    end
    wr_reg(8'hA7, 8'hFF);
    rchk("p3_drive_w", 8'hA7, 8'h01);
    wr_reg(8'hF4, 8'hFE);
    rchk("p3_analog_w", 8'hF4, 8'h00);
    settle;
    chk("p3_rx", 25'h0, 25'(prx[24]));
    rchk("p3_read", 8'hB0, 8'h00);
    wr_reg(8'hE2, 8'h00);
    settle;
    chk("gated_oe", 25'h0, 25'(poe[19:0]));
    tally_and_finish;
  end
endmodule
`default_nettype wire
